// ---- src/txrxc_pkg.sv ----
/*
  txrxc_pkg: constants and types for the transmit/receive command
  chaining, reset and node-identifier wake-up block.
  assumes: a 100 MHz pclk, APB register access with byte addresses.
*/
package txrxc_pkg;

  // ***************
  // register byte addresses
  // ***************
  localparam logic [7:0] ADDR_CMD    = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_CFG    = 8'h08;
  localparam logic [7:0] ADDR_SETUP  = 8'h0c;
  localparam logic [7:0] ADDR_NODE   = 8'h10;
  localparam logic [7:0] ADDR_MASK   = 8'h14;

  // ***************
  // command word fields and opcodes
  // ***************
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_PG_LSB = 3;
  localparam logic [2:0] OP_EN_TX  = 3'h1;
  localparam logic [2:0] OP_EN_RX  = 3'h2;
  localparam logic [2:0] OP_CLR_TX = 3'h3;
  localparam logic [2:0] OP_CLR_RX = 3'h4;
  localparam logic [2:0] OP_DIS_TX = 3'h5;
  localparam logic [2:0] OP_DIS_RX = 3'h6;

  // ***************
  // field positions
  // ***************
  localparam int CFG_SRST_BIT  = 7;
  localparam int CFG_CHAIN_BIT = 6;
  localparam int SETUP_SF_LSB  = 0;
  localparam int MASK_TX_BIT   = 0;
  localparam int MASK_RX_BIT   = 1;
  localparam int ST_TA    = 0;
  localparam int ST_TMA   = 1;
  localparam int ST_TTA   = 2;
  localparam int ST_RI    = 3;
  localparam int ST_TRI   = 4;
  localparam int ST_IRQ   = 5;
  localparam int ST_AWAKE = 6;
  localparam int ST_RST   = 7;
  localparam int ST_TXQ   = 8;
  localparam int ST_RXQ   = 10;

  // ***************
  // reset values and ram pattern
  // ***************
  localparam logic [7:0] CFG_RST   = 8'h00;
  localparam logic [7:0] SETUP_RST = 8'h00;
  localparam logic [1:0] MASK_RST  = 2'h0;
  localparam logic [7:0] RAM_PATTERN = 8'hd1;

  // ***************
  // timing
  // ***************
  localparam int CLK_NS        = 10;
  localparam int IRQ_GAP_NS    = 200;
  localparam int OSC_PERIOD_NS = 10;
  localparam int RST_MIN_OSC   = 5;
  localparam logic [7:0] IRQ_GAP_CYC =
    8'((IRQ_GAP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] RST_MIN_CYC =
    4'((RST_MIN_OSC * OSC_PERIOD_NS + CLK_NS - 1) / CLK_NS);

  typedef enum logic [1:0] {
    RAM_IDLE = 2'b00,
    RAM_WR0  = 2'b01,
    RAM_WR1  = 2'b10
  } txrxc_ram_st_t;

endpackage : txrxc_pkg

// ---- src/txrxc_top.sv ----
/*
  txrxc_top: two-deep transmit and receive command queues with
  double-buffered completion status, interrupt spacing, glitch-filtered
  hardware reset, software reset and node-identifier wake-up writes.
  assumes: APB master on pclk; protocol engine signals on pclk;
  hardware_reset_n_pin asynchronous to pclk.
*/
// Implementation choices: register access over APB and the address map.
// Notes on behaviour
// - first transmit clears available and acked flags
// - chaining accepts second transmit, stores page
// - transmit done sets event, raises interrupt
// - only clear-transmit command clears event, interrupt
// - transmit status double buffered, one interrupt
// - interrupt inactive 200ns between assertions
// - acked flag buffered per transmission, no interrupt
// - next token starts stored second transmission
// - after clear, second result posted, interrupt
// - chaining: transmit mask gates done event only
// - transmit done event set only by transmission
// - disable-transmit cancels oldest unless already started
// - chaining accepts two receives, done raises interrupt
// - only clear-receive clears event; status buffered
// - second receive page used, posted after clear
// - receive mask gates done event; set by reception
// - disable-receive cancels oldest unless already started
// - config bit 7 holds soft reset, keeps setup
// - hardware reset needs five oscillator periods low
// - any reset disables transmitter; hardware reset resets registers
// - nonzero node identifier write wakes core
// - node write: pattern to ram 0, id to 1
// - non-chaining default; chaining while config bit 6
// - two transmits, two receives pending, any order
`timescale 1ns/1ps
module txrxc_top
  import txrxc_pkg::*;
#(
  parameter int RAM_AW = 11
)
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              hardware_reset_n_pin,
  input  wire logic              tx_token,
  input  wire logic              tx_done,
  input  wire logic              tx_acked,
  output logic                   tx_start,
  output logic      [2:0]        tx_page,
  output logic                   rx_enable,
  output logic      [2:0]        rx_page,
  input  wire logic              rx_started,
  input  wire logic              rx_done,
  output logic                   irq_out,
  output logic                   ram_we,
  output logic      [RAM_AW-1:0] ram_addr,
  output logic      [7:0]        ram_wdata,
  output logic                   core_awake,
  output logic                   core_reset
);

  initial
  begin
    if (RAM_AW < 1)
    begin
      $error("txrxc_top: RAM_AW must be at least 1");
    end
  end

  // ***************
  // state
  // ***************
  typedef struct packed {
    logic                rst_s1;
    logic                rst_s2;
    logic [3:0]          rst_cnt;
    logic                hw_rst;
    logic [7:0]          cfg;
    logic [7:0]          setup;
    logic [7:0]          node_id;
    logic [1:0]          mask;
    logic [1:0]          txq_v;
    logic [1:0][2:0]     txq_pg;
    logic                tx_busy;
    logic                tx_start;
    logic [2:0]          tx_page;
    logic                tma_last;
    logic [1:0]          txs_v;
    logic [1:0]          txs_ack;
    logic [1:0]          rxq_v;
    logic [1:0][2:0]     rxq_pg;
    logic                rx_busy;
    logic [1:0]          rxs_v;
    logic                irq;
    logic [7:0]          gap;
    txrxc_ram_st_t       ram_st;
    logic                ram_we;
    logic [RAM_AW-1:0]   ram_addr;
    logic [7:0]          ram_wdata;
    logic [31:0]         prdata;
    logic                pslverr;
  } txrxc_state_t;

  txrxc_state_t state_reg;
  txrxc_state_t state_next;

  // ***************
  // helpers
  // ***************
  function automatic logic [7:0] gap_len(input logic [1:0] sf);
    logic [7:0] mult;
    mult = (sf == 2'h0) ? 8'h01 : {6'h00, sf};
    gap_len = 8'(IRQ_GAP_CYC * mult);
  endfunction : gap_len

  function automatic logic [1:0] q_pop(input logic [1:0] v);
    q_pop = {1'b0, v[1]};
  endfunction : q_pop

  function automatic logic [1:0] q_push(input logic [1:0] v);
    q_push = v[0] ? 2'b11 : 2'b01;
  endfunction : q_push

  // ***************
  // combinational view
  // ***************
  logic       chain;
  logic       sreset;
  logic       any_rst;
  logic       ta_flag;
  logic       ri_flag;
  logic       tma_view;
  logic       wr_acc;
  logic       cmd_wr;
  logic [2:0] cmd_op;
  logic [2:0] cmd_pg;
  logic       irq_want;
  logic [31:0] status_word;

  assign chain    = state_reg.cfg[CFG_CHAIN_BIT];
  assign sreset   = state_reg.cfg[CFG_SRST_BIT];
  assign any_rst  = state_reg.hw_rst | sreset;
  assign ta_flag  = ~(state_reg.txq_v[0] | state_reg.tx_busy);
  assign ri_flag  = ~state_reg.rxq_v[0];
  assign tma_view = chain ? state_reg.txs_ack[0]
                          : state_reg.tma_last;
  assign wr_acc   = psel & penable & pwrite;
  assign cmd_wr   = wr_acc & (paddr == ADDR_CMD) & ~any_rst;
  assign cmd_op   = pwdata[CMD_OP_LSB +: 3];
  assign cmd_pg   = pwdata[CMD_PG_LSB +: 3];

  // chaining: masks gate the done events only
  assign irq_want = chain ?
    ((state_reg.txs_v[0] & state_reg.mask[MASK_TX_BIT]) |
     (state_reg.rxs_v[0] & state_reg.mask[MASK_RX_BIT])) :
    ((ta_flag & state_reg.mask[MASK_TX_BIT]) |
     (ri_flag & state_reg.mask[MASK_RX_BIT]));

  always_comb
  begin
    status_word                      = 32'h0000_0000;
    status_word[ST_TA]               = ta_flag;
    status_word[ST_TMA]              = tma_view;
    status_word[ST_TTA]              = state_reg.txs_v[0];
    status_word[ST_RI]               = ri_flag;
    status_word[ST_TRI]              = state_reg.rxs_v[0];
    status_word[ST_IRQ]              = state_reg.irq;
    status_word[ST_AWAKE]            = core_awake;
    status_word[ST_RST]              = any_rst;
    status_word[ST_TXQ +: 2]         = state_reg.txq_v;
    status_word[ST_RXQ +: 2]         = state_reg.rxq_v;
  end

  // ***************
  // next state
  // ***************
  always_comb
  begin
    logic tx_dis;
    logic rx_dis;
    logic clr_tx;
    logic clr_rx;
    logic rx_go;
    tx_dis = 1'b0;
    rx_dis = 1'b0;
    clr_tx = 1'b0;
    clr_rx = 1'b0;
    rx_go  = 1'b0;
    state_next          = state_reg;
    state_next.tx_start = 1'b0;
    state_next.ram_we   = 1'b0;

    // reset pin: synchroniser then low-time counter
    state_next.rst_s1 = hardware_reset_n_pin;
    state_next.rst_s2 = state_reg.rst_s1;
    if (!state_reg.rst_s2)
    begin
      if (state_reg.rst_cnt != RST_MIN_CYC)
      begin
        state_next.rst_cnt = 4'(state_reg.rst_cnt + 4'h1);
      end
      else
      begin
        state_next.hw_rst = 1'b1;
      end
    end
    else
    begin
      state_next.rst_cnt = 4'h0;
      state_next.hw_rst  = 1'b0;
    end

    // status clears first so a same-cycle completion lands behind
    if (cmd_wr && cmd_op == OP_CLR_TX)
    begin
      clr_tx              = 1'b1;
      state_next.txs_v    = q_pop(state_reg.txs_v);
      state_next.txs_ack  = {1'b0, state_reg.txs_ack[1]};
    end
    if (cmd_wr && cmd_op == OP_CLR_RX)
    begin
      clr_rx           = 1'b1;
      state_next.rxs_v = q_pop(state_reg.rxs_v);
    end

    // transmit queue
    if (cmd_wr && cmd_op == OP_DIS_TX && state_reg.txq_v[0]
        && !state_reg.tx_busy)
    begin
      tx_dis              = 1'b1;
      state_next.txq_v    = q_pop(state_reg.txq_v);
      state_next.txq_pg[0] = state_reg.txq_pg[1];
    end
    if (tx_done && state_reg.tx_busy)
    begin
      state_next.tx_busy   = 1'b0;
      state_next.txq_v     = q_pop(state_reg.txq_v);
      state_next.txq_pg[0] = state_reg.txq_pg[1];
      state_next.tma_last  = tx_acked;
      if (chain)
      begin
        if (state_next.txs_v[0])
        begin
          state_next.txs_ack[1] = tx_acked;
        end
        else
        begin
          state_next.txs_ack[0] = tx_acked;
        end
        state_next.txs_v = q_push(state_next.txs_v);
      end
    end
    if (tx_token && state_reg.txq_v[0] && !state_reg.tx_busy
        && !tx_dis && !(chain && (&state_reg.txs_v)))
    begin
      state_next.tx_busy  = 1'b1;
      state_next.tx_start = 1'b1;
      state_next.tx_page  = state_reg.txq_pg[0];
    end
    if (cmd_wr && cmd_op == OP_EN_TX && !state_next.txq_v[1]
        && (chain || !state_next.txq_v[0]))
    begin
      if (state_next.txq_v[0])
      begin
        state_next.txq_pg[1] = cmd_pg;
      end
      else
      begin
        state_next.txq_pg[0] = cmd_pg;
      end
      state_next.txq_v = q_push(state_next.txq_v);
      if (ta_flag)
      begin
        state_next.tma_last = 1'b0;
      end
    end

    // receive queue
    rx_go = rx_enable;
    if (cmd_wr && cmd_op == OP_DIS_RX && state_reg.rxq_v[0]
        && !state_reg.rx_busy && !(rx_go && rx_started))
    begin
      rx_dis               = 1'b1;
      state_next.rxq_v     = q_pop(state_reg.rxq_v);
      state_next.rxq_pg[0] = state_reg.rxq_pg[1];
    end
    if (rx_go && rx_started && !rx_dis)
    begin
      state_next.rx_busy = 1'b1;
    end
    if (rx_done && state_reg.rx_busy)
    begin
      state_next.rx_busy   = 1'b0;
      state_next.rxq_v     = q_pop(state_reg.rxq_v);
      state_next.rxq_pg[0] = state_reg.rxq_pg[1];
      if (chain)
      begin
        state_next.rxs_v = q_push(state_next.rxs_v);
      end
    end
    if (cmd_wr && cmd_op == OP_EN_RX && !state_next.rxq_v[1]
        && (chain || !state_next.rxq_v[0]))
    begin
      if (state_next.rxq_v[0])
      begin
        state_next.rxq_pg[1] = cmd_pg;
      end
      else
      begin
        state_next.rxq_pg[0] = cmd_pg;
      end
      state_next.rxq_v = q_push(state_next.rxq_v);
    end

    // interrupt with enforced inactive gap
    if (state_reg.irq)
    begin
      if (!irq_want || clr_tx || clr_rx)
      begin
        state_next.irq = 1'b0;
        state_next.gap =
          gap_len(state_reg.setup[SETUP_SF_LSB +: 2]);
      end
    end
    else if (state_reg.gap != 8'h00)
    begin
      state_next.gap = 8'(state_reg.gap - 8'h01);
    end
    else
    begin
      state_next.irq = irq_want;
    end

    // node identifier wake-up writes
    case (state_reg.ram_st)
      RAM_WR0:
      begin
        state_next.ram_we    = 1'b1;
        state_next.ram_addr  = '0;
        state_next.ram_wdata = RAM_PATTERN;
        state_next.ram_st    = RAM_WR1;
      end
      RAM_WR1:
      begin
        state_next.ram_we    = 1'b1;
        state_next.ram_addr  = RAM_AW'(1);
        state_next.ram_wdata = state_reg.node_id;
        state_next.ram_st    = RAM_IDLE;
      end
      default:
      begin
        state_next.ram_st = RAM_IDLE;
      end
    endcase

    // register writes
    if (wr_acc)
    begin
      case (paddr)
        ADDR_CFG:
        begin
          state_next.cfg = pwdata[7:0];
        end
        ADDR_SETUP:
        begin
          state_next.setup = pwdata[7:0];
        end
        ADDR_MASK:
        begin
          state_next.mask = pwdata[1:0];
        end
        ADDR_NODE:
        begin
          if (!any_rst)
          begin
            state_next.node_id = pwdata[7:0];
            state_next.ram_st  = RAM_WR0;
          end
        end
        default:
        begin
        end
      endcase
    end

    // read data and error flag captured in the setup cycle
    if (psel && !penable)
    begin
      state_next.pslverr = 1'b0;
      case (paddr)
        ADDR_CMD:    state_next.prdata = 32'h0000_0000;
        ADDR_STATUS: state_next.prdata = status_word;
        ADDR_CFG:    state_next.prdata = {24'h000000, state_reg.cfg};
        ADDR_SETUP:  state_next.prdata = {24'h000000, state_reg.setup};
        ADDR_NODE:   state_next.prdata = {24'h000000, state_reg.node_id};
        ADDR_MASK:   state_next.prdata = {30'h00000000, state_reg.mask};
        default:
        begin
          state_next.prdata  = 32'h0000_0000;
          state_next.pslverr = 1'b1;
        end
      endcase
    end

    // any reset: transmitter off, core state cleared
    if (any_rst)
    begin
      state_next.txq_v    = 2'b00;
      state_next.tx_busy  = 1'b0;
      state_next.tx_start = 1'b0;
      state_next.tma_last = 1'b0;
      state_next.txs_v    = 2'b00;
      state_next.txs_ack  = 2'b00;
      state_next.rxq_v    = 2'b00;
      state_next.rx_busy  = 1'b0;
      state_next.rxs_v    = 2'b00;
      state_next.irq      = 1'b0;
      state_next.gap      = 8'h00;
      state_next.node_id  = 8'h00;
      state_next.ram_st   = RAM_IDLE;
      state_next.ram_we   = 1'b0;
    end
    if (state_reg.hw_rst)
    begin
      state_next.cfg   = CFG_RST;
      state_next.setup = SETUP_RST;
      state_next.mask  = MASK_RST;
    end
  end

  // ***************
  // registers
  // ***************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= '{rst_s1: 1'b1, rst_s2: 1'b1, cfg: CFG_RST,
                     setup: SETUP_RST, mask: MASK_RST,
                     ram_st: RAM_IDLE, default: '0};
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // ***************
  // outputs
  // ***************
  assign prdata     = state_reg.prdata;
  assign pready     = 1'b1;
  assign pslverr    = psel & penable & state_reg.pslverr;
  assign tx_start   = state_reg.tx_start;
  assign tx_page    = state_reg.tx_page;
  assign rx_enable  = state_reg.rxq_v[0] & ~state_reg.rx_busy
                      & ~(chain & (&state_reg.rxs_v));
  assign rx_page    = state_reg.rxq_pg[0];
  assign irq_out    = state_reg.irq;
  assign ram_we     = state_reg.ram_we;
  assign ram_addr   = state_reg.ram_addr;
  assign ram_wdata  = state_reg.ram_wdata;
  assign core_awake = state_reg.node_id != 8'h00;
  assign core_reset = any_rst;

endmodule : txrxc_top

// ---- bench/txrxc_properties.sv ----
/*
  txrxc_properties: port-level timing checks for txrxc_top.
  assumes: bound to txrxc_top, one clock pclk, reset presetn.
*/
`timescale 1ns/1ps
module txrxc_properties
  import txrxc_pkg::*;
#(
  parameter int RAM_AW = 11
)
(
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [7:0]        paddr,
  input wire logic [31:0]       pwdata,
  input wire logic              hardware_reset_n_pin,
  input wire logic              tx_token,
  input wire logic              tx_start,
  input wire logic              irq_out,
  input wire logic              ram_we,
  input wire logic [RAM_AW-1:0] ram_addr,
  input wire logic [7:0]        ram_wdata,
  input wire logic              core_awake,
  input wire logic              core_reset
);
  // ***************
  // helper counters
  // ***************
  localparam int GAP_MIN = 20;
  logic [7:0] low_cnt;
  logic [3:0] pin_cnt;
  logic       wr_acc;
  assign wr_acc = psel && penable && pwrite;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      low_cnt <= 8'hff;
      pin_cnt <= 4'h0;
    end
    else
    begin
      low_cnt <= irq_out ? 8'h00 : low_cnt + 8'(low_cnt != 8'hff);
      pin_cnt <= hardware_reset_n_pin ? 4'h0
               : pin_cnt + 4'(pin_cnt != 4'hf);
    end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // **********
  // properties
  // **********
  property p_start_token; tx_start |-> $past(tx_token); endproperty
  property p_start_pulse; tx_start |=> !tx_start; endproperty
  property p_irq_gap; $rose(irq_out) |-> low_cnt >= GAP_MIN; endproperty
  property p_ram_pair;
    ram_we && ram_addr == '0 |-> ram_wdata == RAM_PATTERN
      ##1 (ram_we && ram_addr == RAM_AW'(1));
  endproperty
  property p_node_ram;
    wr_acc && paddr == ADDR_NODE && !core_reset
      |-> ##[1:3] (ram_we && ram_addr == '0);
  endproperty
  property p_wake;
    wr_acc && paddr == ADDR_NODE && !core_reset && pwdata[7:0] != 8'h00
      |-> ##[1:2] core_awake;
  endproperty
  property p_soft;
    wr_acc && paddr == ADDR_CFG && pwdata[CFG_SRST_BIT]
      |-> ##[1:2] core_reset;
  endproperty
  property p_hw; pin_cnt == 4'h8 |-> core_reset; endproperty
  property p_quiet; core_reset [*3] |-> !tx_start && !irq_out; endproperty
  a_start_token: assert property (p_start_token)
    else $error("tx_start without a token");
  a_start_pulse: assert property (p_start_pulse)
    else $error("tx_start longer than one cycle");
  a_irq_gap: assert property (p_irq_gap)
    else $error("interrupt inactive gap too short");
  a_ram_pair: assert property (p_ram_pair)
    else $error("ram write pair wrong");
  a_node_ram: assert property (p_node_ram)
    else $error("node write gave no ram write");
  a_wake: assert property (p_wake)
    else $error("core not awake after node write");
  a_soft: assert property (p_soft)
    else $error("soft reset bit ignored");
  a_hw: assert property (p_hw)
    else $error("long reset pulse not taken");
  a_quiet: assert property (p_quiet)
    else $error("activity while in reset");
  c_start: cover property (tx_start);
  c_irq: cover property ($rose(irq_out));
  c_ram: cover property (ram_we);
endmodule : txrxc_properties

bind txrxc_top txrxc_properties #(.RAM_AW(RAM_AW)) u_props (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .pwdata, .hardware_reset_n_pin,
  .tx_token, .tx_start, .irq_out, .ram_we, .ram_addr, .ram_wdata,
  .core_awake, .core_reset);

// ---- bench/txrxc_engine_model.sv ----
/*
  txrxc_engine_model: network protocol engine seen from the block.
  assumes: tb triggers tokens and receptions; delay set by tx_dly.
*/
`timescale 1ns/1ps
module txrxc_engine_model
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       tx_start,
  input  wire logic       rx_enable,
  input  wire logic       tok_go,
  input  wire logic       rx_go,
  input  wire logic       ack_in,
  input  wire logic [3:0] tx_dly,
  output logic            tx_token,
  output logic            tx_done,
  output logic            tx_acked,
  output logic            rx_started,
  output logic            rx_done
);
  logic [3:0] tcnt, rcnt;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      {tx_token, tx_done, tx_acked, rx_started, rx_done} <= 5'h00;
      {tcnt, rcnt} <= 8'h00;
    end
    else
    begin
      tx_token <= tok_go;
      tx_done <= tcnt == 4'h1;
      // acked only valid with done; toggles otherwise
      tx_acked <= (tcnt == 4'h1) ? ack_in : ~tx_acked;
      tcnt <= tx_start ? tx_dly : tcnt - 4'(tcnt != 4'h0);
      rx_started <= rx_go && rx_enable;
      rx_done <= rcnt == 4'h1;
      rcnt <= (rx_go && rx_enable) ? 4'h5 : rcnt - 4'(rcnt != 4'h0);
    end
endmodule : txrxc_engine_model

// ---- bench/tb.sv ----
/*
  tb: self-checking bench for txrxc_top over APB.
  assumes: engine model on the far side, 100 MHz pclk.
*/
`timescale 1ns/1ps
module tb
  import txrxc_pkg::*;
;
  typedef struct packed {logic [7:0] a; logic [31:0] m, e; logic err;}
    txrxc_row_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic hardware_reset_n_pin, tok_go, rx_go, ack_in, ram_we, irq_out;
  logic tx_token, tx_done, tx_acked, tx_start, rx_enable, rx_started;
  logic rx_done, core_awake, core_reset;
  logic [7:0]  paddr, ram_wdata, ram_id;
  logic [31:0] pwdata, prdata, q;
  logic [2:0]  tx_page, rx_page, last_pg;
  logic [3:0]  tx_dly;
  logic [10:0] ram_addr;
  int error_cnt = 0, total_checks = 0, starts = 0;
  txrxc_row_t rows [7] = '{'{ADDR_CFG, 32'hff, 32'h0, 1'b0},
    '{ADDR_SETUP, 32'h3, 32'h0, 1'b0}, '{ADDR_MASK, 32'h3, 32'h0, 1'b0},
    '{ADDR_NODE, 32'hff, 32'h0, 1'b0}, '{ADDR_CMD, '1, 32'h0, 1'b0},
    '{ADDR_STATUS, 32'hf34, 32'h0, 1'b0}, '{8'h40, '1, 32'h0, 1'b1}};

  txrxc_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .hardware_reset_n_pin, .tx_token,
    .tx_done, .tx_acked, .tx_start, .tx_page, .rx_enable, .rx_page,
    .rx_started, .rx_done, .irq_out, .ram_we, .ram_addr, .ram_wdata,
    .core_awake, .core_reset);
  txrxc_engine_model u_eng (.pclk, .presetn, .tx_start, .rx_enable,
    .tok_go, .rx_go, .ack_in, .tx_dly, .tx_token, .tx_done, .tx_acked,
    .rx_started, .rx_done);

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(negedge pclk)
  begin
    if (tx_start === 1'b1) {starts, last_pg} <= {starts + 1, tx_page};
    if (ram_we === 1'b1 && ram_addr === 11'h1) ram_id <= ram_wdata;
  end

  task automatic chk(input string nm, input logic [31:0] s, x);
    total_checks++;
    if (s !== x)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, x, s);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk) penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    {q, e} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
    @(posedge pclk);
  endtask : apb
  task automatic st;
    apb(1'b0, ADDR_STATUS, 32'h0);
  endtask : st
  task automatic cmd(input logic [2:0] op, pg);
    apb(1'b1, ADDR_CMD, {26'h0, pg, op});
  endtask : cmd
  task automatic go(input bit t);
    if (t) tok_go <= 1'b1;
    else rx_go <= 1'b1;
    @(posedge pclk) {tok_go, rx_go} <= 2'b00;
    @(posedge pclk);
  endtask : go
  task automatic wait_irq(input logic v);
    int n = 0;
    while (irq_out !== v && n < 300)
    begin
      n++;
      @(posedge pclk);
    end
    chk("irq_out", irq_out, v);
  endtask : wait_irq
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : close_out

  initial
  begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    close_out();
  end

  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {hardware_reset_n_pin, tok_go, rx_go, ack_in, tx_dly} = {4'h8, 4'h6};
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (rows[i])
    begin
      apb(1'b0, rows[i].a, 32'h0);
      chk("reg value", q & rows[i].m, rows[i].e);
      chk("pslverr", e, rows[i].err);
    end
    $display("done: reset values");
    apb(1'b1, ADDR_MASK, 32'h3);
    apb(1'b1, ADDR_CFG, 32'h40);
    apb(1'b1, ADDR_SETUP, 32'h1);
    apb(1'b1, ADDR_NODE, 32'h2a);
    repeat (4) @(posedge pclk);
    chk("ram node id", ram_id, 8'h2a);
    chk("core_awake", core_awake, 1'b1);
    $display("done: node wake");
    ack_in <= 1'b1;
    cmd(OP_EN_TX, 3'h3);
    cmd(OP_EN_TX, 3'h5);
    st();
    chk("ta tma", q[ST_TMA:ST_TA], 2'b00);
    chk("tx queue", q[ST_TXQ+:2], 2'b11);
    go(1'b1);
    wait_irq(1'b1);
    chk("first page", last_pg, 3'h3);
    ack_in <= 1'b0;
    go(1'b1);
    repeat (12) @(posedge pclk);
    chk("second page", {starts[7:0], last_pg}, {8'h2, 3'h5});
    st();
    chk("tta tma", {q[ST_TTA], q[ST_TMA]}, 2'b11);
    chk("irq held", irq_out, 1'b1);
    cmd(OP_CLR_TX, 3'h0);
    wait_irq(1'b0);
    wait_irq(1'b1);
    st();
    chk("second tta tma", {q[ST_TTA], q[ST_TMA]}, 2'b10);
    cmd(OP_CLR_TX, 3'h0);
    wait_irq(1'b0);
    st();
    chk("tta cleared", q[ST_TTA], 1'b0);
    $display("done: transmit chain");
    cmd(OP_EN_RX, 3'h2);
    cmd(OP_EN_RX, 3'h4);
    chk("rx page", {rx_enable, rx_page}, 4'ha);
    go(1'b0);
    wait_irq(1'b1);
    chk("next rx page", rx_page, 3'h4);
    go(1'b0);
    repeat (10) @(posedge pclk);
    cmd(OP_CLR_RX, 3'h0);
    wait_irq(1'b0);
    wait_irq(1'b1);
    st();
    chk("second tri", q[ST_TRI], 1'b1);
    cmd(OP_CLR_RX, 3'h0);
    wait_irq(1'b0);
    st();
    chk("tri cleared", q[ST_TRI], 1'b0);
    $display("done: receive chain");
    apb(1'b1, ADDR_MASK, 32'h0);
    tx_dly <= 4'h2;
    cmd(OP_EN_TX, 3'h6);
    go(1'b1);
    repeat (15) @(posedge pclk);
    chk("masked irq", irq_out, 1'b0);
    st();
    chk("masked tta", q[ST_TTA], 1'b1);
    cmd(OP_CLR_TX, 3'h0);
    apb(1'b1, ADDR_MASK, 32'h3);
    $display("done: mask");
    for (int k = 0; k < 2; k++)
    begin
      cmd(k ? OP_EN_RX : OP_EN_TX, 3'h1);
      cmd(k ? OP_EN_RX : OP_EN_TX, 3'h2);
      cmd(k ? OP_DIS_RX : OP_DIS_TX, 3'h0);
      st();
      chk("one left", q[ST_TXQ+2*k+:2], 2'b01);
      cmd(k ? OP_DIS_RX : OP_DIS_TX, 3'h0);
      st();
      chk("none left", q[ST_TXQ+2*k+:2], 2'b00);
    end
    $display("done: disable");
    apb(1'b1, ADDR_CFG, 32'hc0);
    apb(1'b0, ADDR_CFG, 32'h0);
    chk("cfg kept", q, 32'hc0);
    st();
    chk("in reset", {q[ST_RST], core_awake}, 2'b10);
    apb(1'b1, ADDR_CFG, 32'h40);
    apb(1'b0, ADDR_SETUP, 32'h0);
    chk("setup kept", q, 32'h1);
    $display("done: soft reset");
    hardware_reset_n_pin <= 1'b0;
    repeat (3) @(posedge pclk) hardware_reset_n_pin <= 1'b1;
    repeat (12) @(posedge pclk);
    chk("glitch", core_reset, 1'b0);
    hardware_reset_n_pin <= 1'b0;
    repeat (12) @(posedge pclk);
    chk("hw reset", core_reset, 1'b1);
    hardware_reset_n_pin <= 1'b1;
    repeat (6) @(posedge pclk);
    apb(1'b0, ADDR_CFG, 32'h0);
    chk("cfg cleared", q, 32'h0);
    cmd(OP_EN_TX, 3'h1);
    cmd(OP_EN_TX, 3'h2);
    st();
    chk("depth one", q[ST_TXQ+:2], 2'b01);
    $display("done: hardware reset");
    close_out();
  end
endmodule : tb
